// file: common/dsc_map.svh
// Command codes, characters, reset values and timing counts for the command handler
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
`define DSC_CMD_RD_DUAL     8'h75
`define DSC_CMD_WR_DUAL     8'h55
`define DSC_CMD_RD_SINGLE   8'h76
`define DSC_CMD_WR_SINGLE   8'h56
`define DSC_CMD_RESET       8'h58
`define DSC_CMD_RD_SLEEP    8'h79
`define DSC_CMD_WR_SLEEP    8'h59
`define DSC_CMD_SLEEP       8'h5a
`define DSC_CMD_RD_MOTION   8'h61
`define DSC_CH_YES          8'h59
`define DSC_CH_NO           8'h4e
`define DSC_CH_ALL          8'h41
`define DSC_CH_PLUS         8'h2b
`define DSC_CH_MINUS        8'h2d
`define DSC_CH_MOTION       8'h4d
`define DSC_CH_ACK          8'h06
`define DSC_CH_NACK         8'h15
`define DSC_CH_DIGIT1       8'h31
`define DSC_RST_SLEEP_TIME  8'h00
`define DSC_CLK_HZ          25000000
`define DSC_TIMEOUT_MS      2500
`define DSC_TIMEOUT_CYC     ((`DSC_CLK_HZ / 1000) * `DSC_TIMEOUT_MS)
`define DSC_SECOND_CYC      (`DSC_CLK_HZ)
`endif

// file: common/dsc_pkg.sv
// Types shared by the command handler
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_DIR_OFF,
    DSC_DIR_PLUS,
    DSC_DIR_MINUS
  } dsc_dir_type;
  typedef enum logic [2:0] {
    DSC_ST_IDLE,
    DSC_ST_ARG,
    DSC_ST_CONFIRM,
    DSC_ST_SLEEP
  } dsc_state_type;
endpackage : dsc_pkg

// file: logic/dsc_cmd.sv
// Serial command handler: direction modes, module reset and sleep
// How it works
// (RQ1) Write-dual 0x55 takes one argument, Y enables, N disables dual reporting.
// (RQ2) Dual enabled: motion reply and unsolicited report carry + or -.
// (RQ3) Read-single 0x76 replies A when filter off, else + or -.
// (RQ4) Write-single 0x56 argument: A off, + or - restricts direction.
// (RQ5) Single direction: motion reply Y only for chosen direction, else N.
// (RQ6) Reset 0x58 answers ACK, then awaits digits 1,2,3,4.
// (RQ7) Correct reset confirmation: ACK, then all settings return to defaults.
// (RQ8) Wrong digit or inactivity timeout on reset: NACK, request dropped.
// (RQ9) Read-sleep returns the stored sleep seconds 0 to 255.
// (RQ10) Write-sleep stores 0 to 255 seconds; zero disables the timer.
// (RQ11) Timer disabled: wake only on sleep pin edge or serial character.
// (RQ12) Sleep 0x5A: ACK, digits 1-4, ACK, sleep for stored seconds.
// (RQ13) Wrong sleep confirmation or timeout: NACK, stay awake.
// (RQ14) Wake on expiry, pin edge or character; waking character discarded.
// (RQ15) Unsolicited mode enabled: send M on each motion event. The code reports only in idle, with tx_busy low and no character taken.
// (RQ16) Write-sleep decoded as 0x59; digits matched as ASCII 1 to 4.
// (RQ17) Waking character discarded by default, optionally executed.
`timescale 1ns/1ns
`include "dsc_map.svh"
module dsc_cmd #(
  parameter int TIMEOUT_CYC = `DSC_TIMEOUT_CYC,
  parameter int SECOND_CYC  = `DSC_SECOND_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       tx_ready_in,
  output logic            tx_valid_out,
  output logic      [7:0] tx_data_out,
  input  wire logic       motion_in,
  input  wire logic       motion_dir_in,
  input  wire logic       unsolicited_en_in,
  input  wire logic       wake_on_char_exec_in,
  input  wire logic       sleep_wake_pin_in,
  output logic            motion_status_out,
  output logic            dual_en_out,
  output dsc_pkg::dsc_dir_type single_dir_out,
  output logic      [7:0] sleep_time_out,
  output logic            sleep_out
);
  import dsc_pkg::*;

  dsc_state_type state;
  logic [7:0]    arg_cmd;
  logic [1:0]    digit_idx;
  logic          reset_pending;
  logic          dual_en;
  dsc_dir_type   single_dir;
  logic [7:0]    sleep_time;
  logic [31:0]   idle_cnt;
  logic [31:0]   sec_cnt;
  logic [7:0]    sec_left;
  logic          pin_q;
  logic          motion_seen;
  logic          motion_plus;
  logic          soft_reset;
  logic          tx_busy;
  logic          tx_load;
  logic [7:0]    next_tx;
  logic          pin_edge;
  logic          motion_ok;
  logic          take;
  logic          wake;
  logic          wake_exec;
  dsc_state_type dec_state;

  // Motion counts only in the selected direction; with the filter off both directions count
  function automatic logic dir_match(input dsc_dir_type d, input logic plus);
    dir_match = (d == DSC_DIR_OFF) || ((d == DSC_DIR_PLUS) == plus);
  endfunction : dir_match

  function automatic logic [7:0] dir_char(input logic plus);
    dir_char = plus ? `DSC_CH_PLUS : `DSC_CH_MINUS;
  endfunction : dir_char

  // Commands followed by one argument character
  function automatic logic is_arg_cmd(input logic [7:0] c);
    is_arg_cmd = c == `DSC_CMD_WR_DUAL || c == `DSC_CMD_WR_SINGLE ||
                 c == `DSC_CMD_WR_SLEEP;
  endfunction : is_arg_cmd

  function automatic logic is_confirm_cmd(input logic [7:0] c);
    is_confirm_cmd = c == `DSC_CMD_RESET || c == `DSC_CMD_SLEEP;
  endfunction : is_confirm_cmd

  assign pin_edge  = sleep_wake_pin_in != pin_q;
  assign motion_ok = motion_in && dir_match(single_dir, motion_dir_in); // [RQ5]
  assign take      = rx_valid_in && !tx_busy;
  assign wake_exec = take && wake_on_char_exec_in && state == DSC_ST_SLEEP;
  assign dec_state = (state == DSC_ST_SLEEP) ? DSC_ST_IDLE : state;
  assign wake      = (state == DSC_ST_SLEEP) && (pin_edge || rx_valid_in ||
                     (sleep_time != 8'h00 && sec_left == 8'h00 && sec_cnt == 32'h0)); // [RQ14]

  assign tx_valid_out      = tx_busy;
  assign dual_en_out       = dual_en;
  assign single_dir_out    = single_dir;
  assign sleep_time_out    = sleep_time;
  assign sleep_out         = state == DSC_ST_SLEEP;
  assign motion_status_out = motion_seen;

  // Command decode and reply selection
  always_comb begin
    tx_load = 1'b0;
    next_tx = 8'h00;
    if (take && (state != DSC_ST_SLEEP || wake_on_char_exec_in)) begin // [RQ17]
      tx_load = 1'b1;
      unique case (dec_state)
        DSC_ST_IDLE: begin
          unique case (rx_data_in)
            `DSC_CMD_RD_DUAL: next_tx = dual_en ? `DSC_CH_YES : `DSC_CH_NO;
            `DSC_CMD_RD_SINGLE: next_tx = (single_dir == DSC_DIR_OFF) ? `DSC_CH_ALL :
                                dir_char(single_dir == DSC_DIR_PLUS); // [RQ3]
            `DSC_CMD_RD_SLEEP: next_tx = sleep_time; // [RQ9]
            `DSC_CMD_RD_MOTION: next_tx = !motion_seen ? `DSC_CH_NO :
                                dual_en ? dir_char(motion_plus) : `DSC_CH_YES; // [RQ2] [RQ5]
            `DSC_CMD_RESET, `DSC_CMD_SLEEP: next_tx = `DSC_CH_ACK; // [RQ6] [RQ12]
            default: tx_load = 1'b0;
          endcase
        end
        DSC_ST_ARG: tx_load = 1'b0;
        DSC_ST_CONFIRM: begin
          if (rx_data_in != `DSC_CH_DIGIT1 + {6'h00, digit_idx})
            next_tx = `DSC_CH_NACK; // [RQ8] [RQ13]
          else if (digit_idx == 2'd3)
            next_tx = `DSC_CH_ACK; // [RQ7] [RQ12]
          else
            tx_load = 1'b0;
        end
        default: tx_load = 1'b0;
      endcase
    end else if (state == DSC_ST_CONFIRM && !tx_busy && idle_cnt >= TIMEOUT_CYC) begin
      tx_load = 1'b1;
      next_tx = `DSC_CH_NACK; // [RQ8] [RQ13]
    end else if (motion_ok && unsolicited_en_in && !tx_busy && state == DSC_ST_IDLE) begin
      tx_load = 1'b1;
      next_tx = dual_en ? dir_char(motion_dir_in) : `DSC_CH_MOTION; // [RQ15] [RQ2]
    end
  end

  // Transmit holding register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_busy     <= 1'b0;
      tx_data_out <= 8'h00;
    end else if (tx_load) begin
      tx_busy     <= 1'b1;
      tx_data_out <= next_tx;
    end else if (tx_ready_in) begin
      tx_busy <= 1'b0;
    end
  end

  // Command sequencing and sleep
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state         <= DSC_ST_IDLE;
      arg_cmd       <= 8'h00;
      digit_idx     <= 2'd0;
      reset_pending <= 1'b0;
      idle_cnt      <= 32'h0;
      sec_cnt       <= 32'h0;
      sec_left      <= 8'h00;
    end else begin
      unique case (state)
        DSC_ST_IDLE: if (take) begin
          if (is_arg_cmd(rx_data_in)) begin // [RQ16]
            state   <= DSC_ST_ARG;
            arg_cmd <= rx_data_in;
          end else if (is_confirm_cmd(rx_data_in)) begin
            state         <= DSC_ST_CONFIRM;
            reset_pending <= rx_data_in == `DSC_CMD_RESET;
            digit_idx     <= 2'd0;
            idle_cnt      <= 32'h0;
          end
        end
        DSC_ST_ARG: if (take) begin
          state <= DSC_ST_IDLE;
        end
        DSC_ST_CONFIRM: begin
          idle_cnt <= idle_cnt + 32'h1;
          if (take) begin
            idle_cnt  <= 32'h0;
            digit_idx <= digit_idx + 2'd1;
            if (rx_data_in != `DSC_CH_DIGIT1 + {6'h00, digit_idx}) begin
              state <= DSC_ST_IDLE; // [RQ8] [RQ13]
            end else if (digit_idx == 2'd3) begin
              state    <= reset_pending ? DSC_ST_IDLE : DSC_ST_SLEEP; // [RQ12]
              sec_left <= sleep_time;
              sec_cnt  <= SECOND_CYC - 1;
            end
          end else if (tx_load) begin
            state <= DSC_ST_IDLE;
          end
        end
        DSC_ST_SLEEP: begin
          if (sleep_time != 8'h00) begin // [RQ10] [RQ11]
            if (sec_cnt != 32'h0) begin
              sec_cnt <= sec_cnt - 32'h1;
            end else if (sec_left != 8'h00) begin
              sec_left <= sec_left - 8'h1;
              sec_cnt  <= (sec_left == 8'h1) ? 32'h0 : SECOND_CYC - 1;
            end
          end
          if (wake) begin
            state <= DSC_ST_IDLE; // [RQ14]
            // Waking character runs as a command only when enabled
            if (wake_exec && is_arg_cmd(rx_data_in)) begin // [RQ17]
              state   <= DSC_ST_ARG;
              arg_cmd <= rx_data_in;
            end else if (wake_exec && is_confirm_cmd(rx_data_in)) begin
              state         <= DSC_ST_CONFIRM;
              reset_pending <= rx_data_in == `DSC_CMD_RESET;
              digit_idx     <= 2'd0;
              idle_cnt      <= 32'h0;
            end
          end
        end
        default: state <= DSC_ST_IDLE;
      endcase
    end
  end

  // Settings; soft reset restores defaults on the same edge that loads the final ACK
  assign soft_reset = take && state == DSC_ST_CONFIRM && reset_pending && digit_idx == 2'd3 &&
                      rx_data_in == `DSC_CH_DIGIT1 + 8'h03; // [RQ7]

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dual_en    <= 1'b0;
      single_dir <= DSC_DIR_OFF;
      sleep_time <= `DSC_RST_SLEEP_TIME;
    end else if (soft_reset) begin
      dual_en    <= 1'b0;
      single_dir <= DSC_DIR_OFF;
      sleep_time <= `DSC_RST_SLEEP_TIME;
    end else if (take && state == DSC_ST_ARG) begin
      unique case (arg_cmd)
        `DSC_CMD_WR_DUAL: begin
          if (rx_data_in == `DSC_CH_YES) dual_en <= 1'b1; // [RQ1]
          else if (rx_data_in == `DSC_CH_NO) dual_en <= 1'b0;
        end
        `DSC_CMD_WR_SINGLE: begin
          if (rx_data_in == `DSC_CH_ALL) single_dir <= DSC_DIR_OFF; // [RQ4]
          else if (rx_data_in == `DSC_CH_PLUS) single_dir <= DSC_DIR_PLUS;
          else if (rx_data_in == `DSC_CH_MINUS) single_dir <= DSC_DIR_MINUS;
        end
        default: sleep_time <= rx_data_in; // [RQ10]
      endcase
    end
  end

  // Motion status and pin history
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      motion_seen <= 1'b0;
      motion_plus <= 1'b0;
      pin_q       <= 1'b1;
    end else begin
      pin_q <= sleep_wake_pin_in;
      if (soft_reset) begin
        motion_seen <= 1'b0;
      end else if (motion_ok) begin
        motion_seen <= 1'b1;
        motion_plus <= motion_dir_in;
      end
    end
  end

  property p_confirm_ack;
    @(posedge clk_in) disable iff (!resetn_in)
      soft_reset |=> tx_busy && tx_data_out == `DSC_CH_ACK && !dual_en;
  endproperty
  a_confirm_ack: assert property (p_confirm_ack) else $error("reset confirm no ACK"); // [RQ7]

  property p_bad_digit;
    @(posedge clk_in) disable iff (!resetn_in)
      (take && state == DSC_ST_CONFIRM && rx_data_in != `DSC_CH_DIGIT1 + {6'h00, digit_idx})
      |=> tx_data_out == `DSC_CH_NACK && state == DSC_ST_IDLE;
  endproperty
  a_bad_digit: assert property (p_bad_digit) else $error("bad digit no NACK"); // [RQ8]

  property p_cmd_ack;
    @(posedge clk_in) disable iff (!resetn_in)
      (take && state == DSC_ST_IDLE && rx_data_in == `DSC_CMD_SLEEP)
      |=> tx_data_out == `DSC_CH_ACK && state == DSC_ST_CONFIRM;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("sleep cmd no ACK"); // [RQ12]

  property p_dual_write;
    @(posedge clk_in) disable iff (!resetn_in)
      (take && state == DSC_ST_ARG && arg_cmd == `DSC_CMD_WR_DUAL && rx_data_in == `DSC_CH_YES)
      |=> dual_en;
  endproperty
  a_dual_write: assert property (p_dual_write) else $error("dual not set"); // [RQ1]

  property p_sleep_store;
    @(posedge clk_in) disable iff (!resetn_in)
      (take && state == DSC_ST_ARG && arg_cmd == `DSC_CMD_WR_SLEEP)
      |=> sleep_time == $past(rx_data_in);
  endproperty
  a_sleep_store: assert property (p_sleep_store) else $error("sleep time lost"); // [RQ10]

  property p_wake;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == DSC_ST_SLEEP && rx_valid_in && !tx_busy && !wake_on_char_exec_in) |=>
      state == DSC_ST_IDLE && !tx_busy;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on char"); // [RQ14]

  property p_wake_exec;
    @(posedge clk_in) disable iff (!resetn_in)
      (wake_exec && rx_data_in == `DSC_CMD_RD_SINGLE) |=> state == DSC_ST_IDLE && tx_busy;
  endproperty
  a_wake_exec: assert property (p_wake_exec) else $error("waking char not run"); // [RQ17]

  property p_single_reply;
    @(posedge clk_in) disable iff (!resetn_in)
      (take && state == DSC_ST_IDLE && rx_data_in == `DSC_CMD_RD_SINGLE &&
       single_dir == DSC_DIR_OFF) |=> tx_data_out == `DSC_CH_ALL;
  endproperty
  a_single_reply: assert property (p_single_reply) else $error("single read wrong"); // [RQ3]

  property p_unsol;
    @(posedge clk_in) disable iff (!resetn_in)
      (motion_ok && unsolicited_en_in && !tx_busy && state == DSC_ST_IDLE && !rx_valid_in &&
       !dual_en) |=> tx_data_out == `DSC_CH_MOTION;
  endproperty
  a_unsol: assert property (p_unsol) else $error("no M report"); // [RQ15]

  c_sleep: cover property (@(posedge clk_in) state == DSC_ST_CONFIRM ##[1:20] state == DSC_ST_SLEEP);
  c_reset: cover property (@(posedge clk_in) soft_reset);
  c_nack:  cover property (@(posedge clk_in) tx_load && next_tx == `DSC_CH_NACK);
  c_wexec: cover property (@(posedge clk_in) wake_exec);
endmodule : dsc_cmd

// file: test/dsc_host.sv
// Host controller model: sends command bytes and takes reply bytes
`timescale 1ns/1ns
module dsc_host (
  input  wire logic       clk_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  output logic            tx_ready_out
);
  int stall = 0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
  end
  // One byte per strobe
  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    #1;
    rx_valid_out = 1'b1;
    rx_data_out  = b;
    @(posedge clk_in);
    #1;
    rx_valid_out = 1'b0;
    // Released line never keeps the last byte
    rx_data_out  = ~b;
  endtask : send
  // Waits for a reply, optionally stalls, then takes it
  task automatic recv(output logic [7:0] b, output bit got);
    got = 1'b0;
    b   = 8'hxx;
    for (int i = 0; i < 200 && !got; i++) begin
      @(posedge clk_in);
      #1;
      if (tx_valid_in === 1'b1) got = 1'b1;
    end
    if (got) begin
      repeat (stall) @(posedge clk_in);
      #1;
      tx_ready_out = 1'b1;
      @(posedge clk_in);
      b = tx_data_in;
      #1;
      tx_ready_out = 1'b0;
    end
  endtask : recv
endmodule : dsc_host

// file: test/dsc_cmd_tb.sv
// Self-checking bench for the serial command handler
`timescale 1ns/1ns
`include "dsc_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module dsc_cmd_tb;
  import dsc_pkg::*;
  logic        clk_in, resetn_in, rx_valid, tx_ready, tx_valid, motion, mdir, unsol, pin;
  logic [7:0]  rx_data, tx_data, sleep_time;
  logic        mstat, dual_en, sleep, wexec;
  dsc_dir_type single_dir;
  int          failures = 0;
  int          num_checks = 0;
  logic [7:0]  args[3] = '{`DSC_CH_PLUS, `DSC_CH_MINUS, `DSC_CH_ALL};
  dsc_dir_type dirs[3] = '{DSC_DIR_PLUS, DSC_DIR_MINUS, DSC_DIR_OFF};
  dsc_cmd #(.TIMEOUT_CYC(50), .SECOND_CYC(10)) u_dsc_cmd (
    .clk_in(clk_in), .resetn_in(resetn_in), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .motion_in(motion), .motion_dir_in(mdir), .unsolicited_en_in(unsol),
    .wake_on_char_exec_in(wexec), .sleep_wake_pin_in(pin), .motion_status_out(mstat),
    .dual_en_out(dual_en), .single_dir_out(single_dir), .sleep_time_out(sleep_time),
    .sleep_out(sleep));
  dsc_host u_dsc_host (
    .clk_in(clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .tx_ready_out(tx_ready));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic expect_rx(input string nm, input logic [7:0] e);
    logic [7:0] b;
    bit         got;
    u_dsc_host.recv(b, got);
    if (!got) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen none", nm, e);
      finish_test();
    end else begin
      `CHK(nm, e, b)
    end
  endtask : expect_rx
  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    u_dsc_host.send(a);
    u_dsc_host.send(b);
    settle();
  endtask : cmd2
  task automatic pulse(input logic d);
    @(posedge clk_in);
    #1;
    motion = 1'b1;
    mdir   = d;
    @(posedge clk_in);
    #1;
    motion = 1'b0;
  endtask : pulse
  task automatic confirm();
    for (int d = 0; d < 4; d++) u_dsc_host.send(`DSC_CH_DIGIT1 + 8'(d));
  endtask : confirm
  task automatic wait_sleep(input logic e, input int n);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge clk_in);
      #1;
      hit = (sleep === e);
    end
    `CHK("sleep_out", e, sleep)
    if (!hit) finish_test();
  endtask : wait_sleep
  task automatic sleep_seq();
    u_dsc_host.send(`DSC_CMD_SLEEP);
    expect_rx("sleep_ack", `DSC_CH_ACK);
    confirm();
    expect_rx("sleep_ack2", `DSC_CH_ACK);
    wait_sleep(1'b1, 8);
  endtask : sleep_seq
  initial begin
    resetn_in = 1'b0;
    motion = 1'b0;
    mdir = 1'b0;
    unsol = 1'b0;
    pin = 1'b1;
    wexec = 1'b0;
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    settle();
    `CHK("dual_en", 1'b0, dual_en)
    `CHK("single_dir", DSC_DIR_OFF, single_dir)
    `CHK("sleep_time", 8'h00, sleep_time)
    `CHK("sleep_out", 1'b0, sleep)
    $display("test reset_values done");
    cmd2(`DSC_CMD_WR_SINGLE, `DSC_CH_PLUS);
    pulse(1'b0);
    u_dsc_host.send(`DSC_CMD_RD_MOTION);
    expect_rx("motion_opp", `DSC_CH_NO);
    `CHK("motion_status", 1'b0, mstat)
    pulse(1'b1);
    u_dsc_host.send(`DSC_CMD_RD_MOTION);
    expect_rx("motion_sel", `DSC_CH_YES);
    $display("test single_filter done");
    for (int i = 0; i < 3; i++) begin
      cmd2(`DSC_CMD_WR_SINGLE, args[i]);
      `CHK("single_dir", dirs[i], single_dir)
      u_dsc_host.send(`DSC_CMD_RD_SINGLE);
      expect_rx("rd_single", args[i]);
    end
    $display("test single_modes done");
    unsol = 1'b1;
    pulse(1'b1);
    expect_rx("report", `DSC_CH_MOTION);
    cmd2(`DSC_CMD_WR_DUAL, `DSC_CH_YES);
    `CHK("dual_en", 1'b1, dual_en)
    u_dsc_host.stall = 3;
    pulse(1'b0);
    expect_rx("dual_minus", `DSC_CH_MINUS);
    pulse(1'b1);
    expect_rx("dual_plus", `DSC_CH_PLUS);
    u_dsc_host.send(`DSC_CMD_RD_MOTION);
    expect_rx("motion_dual", `DSC_CH_PLUS);
    u_dsc_host.send(`DSC_CMD_RD_DUAL);
    expect_rx("rd_dual", `DSC_CH_YES);
    u_dsc_host.stall = 0;
    unsol = 1'b0;
    $display("test reports done");
    cmd2(`DSC_CMD_WR_SLEEP, 8'h03);
    `CHK("sleep_time", 8'h03, sleep_time)
    u_dsc_host.send(`DSC_CMD_RD_SLEEP);
    expect_rx("rd_sleep", 8'h03);
    u_dsc_host.send(`DSC_CMD_SLEEP);
    expect_rx("sleep_ack", `DSC_CH_ACK);
    u_dsc_host.send(`DSC_CH_DIGIT1);
    u_dsc_host.send(`DSC_CH_DIGIT1 + 8'h02);
    expect_rx("sleep_nack", `DSC_CH_NACK);
    settle();
    `CHK("sleep_out", 1'b0, sleep)
    u_dsc_host.send(`DSC_CMD_SLEEP);
    expect_rx("sleep_ack", `DSC_CH_ACK);
    expect_rx("sleep_tmo", `DSC_CH_NACK);
    `CHK("sleep_out", 1'b0, sleep)
    sleep_seq();
    repeat (20) @(posedge clk_in);
    #1;
    `CHK("sleep_out", 1'b1, sleep)
    wait_sleep(1'b0, 12);
    $display("test timed_sleep done");
    cmd2(`DSC_CMD_WR_SLEEP, 8'h00);
    sleep_seq();
    repeat (60) @(posedge clk_in);
    #1;
    `CHK("sleep_out", 1'b1, sleep)
    pin = ~pin;
    wait_sleep(1'b0, 8);
    sleep_seq();
    u_dsc_host.send(`DSC_CMD_RD_SINGLE);
    wait_sleep(1'b0, 8);
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("tx_valid", 1'b0, tx_valid)
    wexec = 1'b1;
    sleep_seq();
    u_dsc_host.send(`DSC_CMD_RD_SINGLE);
    expect_rx("wake_exec", `DSC_CH_ALL);
    `CHK("sleep_out", 1'b0, sleep)
    wexec = 1'b0;
    $display("test wake_sources done");
    cmd2(`DSC_CMD_WR_SINGLE, `DSC_CH_MINUS);
    cmd2(`DSC_CMD_WR_SLEEP, 8'h05);
    u_dsc_host.send(`DSC_CMD_RESET);
    expect_rx("reset_ack", `DSC_CH_ACK);
    u_dsc_host.send(`DSC_CH_DIGIT1);
    repeat (40) @(posedge clk_in);
    #1;
    `CHK("tx_valid", 1'b0, tx_valid)
    expect_rx("reset_tmo", `DSC_CH_NACK);
    `CHK("dual_en", 1'b1, dual_en)
    u_dsc_host.send(`DSC_CMD_RESET);
    expect_rx("reset_ack", `DSC_CH_ACK);
    u_dsc_host.send(`DSC_CH_DIGIT1 + 8'h01);
    expect_rx("reset_nack", `DSC_CH_NACK);
    `CHK("single_dir", DSC_DIR_MINUS, single_dir)
    u_dsc_host.send(`DSC_CMD_RESET);
    expect_rx("reset_ack", `DSC_CH_ACK);
    confirm();
    expect_rx("reset_ack2", `DSC_CH_ACK);
    settle();
    `CHK("dual_en", 1'b0, dual_en)
    `CHK("single_dir", DSC_DIR_OFF, single_dir)
    `CHK("sleep_time", 8'h00, sleep_time)
    `CHK("motion_status", 1'b0, mstat)
    $display("test module_reset done");
    finish_test();
  end
endmodule : dsc_cmd_tb
